// *** logic/sdp_debug_port.sv ***
// Top: serial debug port giving word access to the memory space
// Behaviour
// (R1) Sixteen-bit addresses and sixteen-bit data words
// (R2) Works whether processor runs or halts
// (R3) Two clocks deselected resets serial state
// (R4) Transaction starts with eight-bit command
// (R5) Sixteen-bit address follows the command
// (R6) Data words follow the address
// (R7) Master holds select low; rising ends
// (R8) Input sampled on serial clock rise
// (R9) Output changes on serial clock fall
// (R10) Serial clock is input only
// (R11) Each further sixteen clocks advances address
// (R12) Deselected output: 0 running, 1 halted
// (R13) Output must not share other slaves
// (R14) Read command code is 00000011
// (R15) Read returns check word, then data
// (R16) Reads continue through successive locations
// (R17) Write command 00000010 stores words
// (R18) Synchronised clock; one request per word
`timescale 1ns/1ps
`default_nettype none
module sdp_debug_port (
  input  wire logic        sys_clk,    // System clock, 50 MHz
  input  wire logic        rst_n,      // Async reset, active low
  input  wire logic        ce,         // Clock enable, freezes state when low
  input  wire logic        spi_clk,    // Serial clock from master
  input  wire logic        spi_cs_n,   // Chip select, active low
  input  wire logic        spi_mosi,   // Serial data in
  output logic             spi_miso,   // Serial data out, always driven
  input  wire logic        cpu_halted, // Processor halted status
  output logic             mem_en,     // Memory strobe
  output logic             mem_we,     // Memory write enable
  output logic [15:0]      mem_addr,   // Memory address
  output logic [15:0]      mem_wdata,  // Memory write data
  input  wire logic [15:0] mem_rdata   // Memory read data
);
  // ==========================================================
  // Input synchronisers
  logic sclk_q, sclk_rise, sclk_fall;
  logic cs_q, cs_rise, cs_fall;
  logic mosi_q;
  sdp_sync #(.RST_VAL(1'b0)) u_sclk (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .d(spi_clk),
    .q(sclk_q), .rise(sclk_rise), .fall(sclk_fall)); // see (R10) (R18)
  sdp_sync #(.RST_VAL(1'b1)) u_cs (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .d(spi_cs_n),
    .q(cs_q), .rise(cs_rise), .fall(cs_fall));
  sdp_sync #(.RST_VAL(1'b0)) u_mosi (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .d(spi_mosi),
    .q(mosi_q), .rise(), .fall());
  logic halt_s1, halt_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_s1 <= 1'b0;
      halt_q  <= 1'b0;
    end else if (ce) begin
      halt_s1 <= cpu_halted;
      halt_q  <= halt_s1;
    end
  end

  // ==========================================================
  // Memory side
  sdp_mem_if mif ();
  sdp_mem_port u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .mif(mif), .mem_en(mem_en),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ==========================================================
  // Serial engine
  typedef enum logic [2:0] {SDP_IDLE, SDP_CMD, SDP_ADDR, SDP_DATA, SDP_SKIP} sdp_state_t;
  sdp_state_t  state;
  logic [4:0]  bit_cnt;
  logic [7:0]  cmd;
  logic [15:0] addr;
  logic [15:0] shreg;
  logic [15:0] tx;
  logic [15:0] rdbuf;
  logic        req;
  logic        req_we;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic [1:0]  hi_cnt;
  logic        armed;
  logic        miso;

  wire         selected   = ~cs_q & armed;
  wire         in_cmd     = state == SDP_CMD;
  wire         in_addr    = state == SDP_ADDR;
  wire         in_data    = state == SDP_DATA;
  wire         is_read    = cmd == sdp_pkg::CMD_READ;
  wire         is_write   = cmd == sdp_pkg::CMD_WRITE;
  wire  [7:0]  next_cmd   = {shreg[6:0], mosi_q};
  wire  [15:0] next_shreg = {shreg[14:0], mosi_q};
  wire         cmd_done   = in_cmd & sclk_rise & (bit_cnt == sdp_pkg::CMD_LAST);
  wire         word_done  = sclk_rise & (bit_cnt == sdp_pkg::WORD_LAST);
  wire         addr_done  = in_addr & word_done;
  wire         data_done  = in_data & word_done;
  wire         cmd_read   = next_cmd == sdp_pkg::CMD_READ;
  wire         cmd_known  = cmd_read | (next_cmd == sdp_pkg::CMD_WRITE);
  // Check word is the command plus upper address byte
  wire  [15:0] check_word = {cmd, next_shreg[15:8]}; // see (R15)

  assign mif.req   = req;
  assign mif.we    = req_we;
  assign mif.addr  = req_addr;
  assign mif.wdata = req_wdata;

  // Deselect counter: two serial clocks with select high arm the engine once after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 2'h0;
      armed  <= 1'b0;
    end else if (ce) begin
      if (!cs_q) begin
        hi_cnt <= 2'h0;
      end else if (sclk_rise && hi_cnt != 2'(sdp_pkg::RESYNC_EDGES)) begin
        hi_cnt <= hi_cnt + 2'h1;
      end
      if (cs_q && hi_cnt == 2'(sdp_pkg::RESYNC_EDGES)) begin
        armed <= 1'b1; // see (R3)
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= SDP_IDLE;
      bit_cnt <= 5'h00;
      cmd     <= 8'h00;
      addr    <= 16'h0000;
      shreg   <= 16'h0000;
    end else if (ce) begin
      if (cs_q || !armed) begin
        state   <= SDP_IDLE; // see (R7)
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin // see (R8)
        shreg   <= next_shreg;
        bit_cnt <= word_done ? 5'h00 : bit_cnt + 5'h01;
        unique case (state)
          SDP_IDLE: begin
            state   <= SDP_CMD; // see (R4)
            bit_cnt <= 5'h01;
          end
          SDP_CMD: begin
            if (cmd_done) begin
              cmd     <= next_cmd;
              state   <= cmd_known ? SDP_ADDR : SDP_SKIP;
              bit_cnt <= 5'h00;
            end
          end
          SDP_ADDR: begin
            if (addr_done) begin
              addr  <= next_shreg; // see (R5)
              state <= SDP_DATA;
            end
          end
          SDP_DATA: begin
            if (data_done) begin
              addr <= addr + 16'h0001; // see (R11)
            end
          end
          SDP_SKIP: ;
        endcase
      end
    end
  end

  // One request per completed data word, and one for the address word of a read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req       <= 1'b0;
      req_we    <= 1'b0;
      req_addr  <= 16'h0000;
      req_wdata <= 16'h0000;
      rdbuf     <= 16'h0000;
    end else if (ce) begin
      req <= 1'b0;
      if (selected && addr_done && is_read) begin
        req      <= 1'b1; // see (R18) (R14)
        req_we   <= 1'b0;
        req_addr <= next_shreg;
      end else if (selected && data_done && is_read) begin
        req      <= 1'b1; // see (R16)
        req_we   <= 1'b0;
        req_addr <= addr + 16'h0001;
      end else if (selected && data_done && is_write) begin
        req       <= 1'b1; // see (R17) (R6) (R1)
        req_we    <= 1'b1;
        req_addr  <= addr;
        req_wdata <= next_shreg;
      end
      if (mif.ack && !req_we) begin
        rdbuf <= mif.rdata;
      end
    end
  end

  // Transmit shifter: loads on word boundary, shifts on falling clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx   <= 16'h0000;
      miso <= 1'b0;
    end else if (ce) begin
      if (cs_q || !armed) begin
        miso <= halt_q; // see (R12) (R2)
      end else if (sclk_fall && in_data && is_read) begin
        miso <= tx[15]; // see (R9)
        tx   <= {tx[14:0], 1'b0};
      end
      // Load at word end, before the prefetch overwrites the read buffer
      if (selected && addr_done && is_read) begin
        tx <= check_word; // see (R15)
      end else if (selected && data_done && is_read) begin
        tx <= rdbuf; // see (R16)
      end
    end
  end

  property p_data_load;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && selected && data_done && is_read) |=> (tx == $past(rdbuf));
  endproperty
  a_data_load: assert property (p_data_load) else $error("read word not loaded"); // see (R16)

  assign spi_miso = miso;

  // ==========================================================
  // Checks
  property p_desel_level;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && $past(ce) && $past(cs_q) && $past(cs_q, 2)) |-> (spi_miso == $past(halt_q));
  endproperty
  a_desel_level: assert property (p_desel_level) else $error("miso not idle level"); // see (R12)

  property p_one_req;
    @(posedge sys_clk) disable iff (!rst_n)
      req |=> !req;
  endproperty
  a_one_req: assert property (p_one_req) else $error("request longer than one cycle"); // see (R18)

  property p_wr_req;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && selected && data_done && is_write) |=> (req && req_we && req_addr == $past(addr));
  endproperty
  a_wr_req: assert property (p_wr_req) else $error("write request missing"); // see (R17)

  property p_addr_inc;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && selected && data_done) |=> (addr == $past(addr) + 16'h0001);
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address not advanced"); // see (R11)

  property p_check_word;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && selected && addr_done && is_read) |=> (tx == {cmd, $past(next_shreg[15:8])});
  endproperty
  a_check_word: assert property (p_check_word) else $error("check word wrong"); // see (R15)

  property p_miso_fall;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && !cs_q && $past(!cs_q) && !sclk_fall && state != SDP_IDLE) |=> $stable(spi_miso);
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved off falling edge"); // see (R9)

  property p_cs_end;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && cs_q) |=> (state == SDP_IDLE);
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("transaction not ended"); // see (R7)

  property p_cmd_latch;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && selected && cmd_done) |=> (cmd == $past(next_cmd) && state != SDP_CMD);
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("command not captured"); // see (R4)
endmodule : sdp_debug_port
`default_nettype wire

// *** logic/sdp_pkg.sv ***
// Package: constants for the serial debug memory port
package sdp_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 16;
  localparam int          CMD_W        = 8;
  localparam logic [7:0]  CMD_READ     = 8'h03;
  localparam logic [7:0]  CMD_WRITE    = 8'h02;
  localparam int          RESYNC_EDGES = 2;
  localparam logic [4:0]  CMD_LAST     = 5'h07;
  localparam logic [4:0]  WORD_LAST    = 5'h0f;
endpackage : sdp_pkg

// *** logic/sdp_mem_if.sv ***
// Interface: word request port between serial engine and memory side
`timescale 1ns/1ps
`default_nettype none
interface sdp_mem_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  modport master (output req, output we, output addr, output wdata, input rdata, input ack);
  modport slave  (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface : sdp_mem_if
`default_nettype wire

// *** logic/sdp_sync.sv ***
// Two-flop synchroniser with rise/fall detection after the second stage
`timescale 1ns/1ps
`default_nettype none
module sdp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk,  // System clock
  input  wire logic rst_n,    // Async reset, active low
  input  wire logic ce,       // Clock enable
  input  wire logic d,        // Asynchronous input
  output var  logic q,        // Synchronised level
  output logic      rise,     // One-cycle rising edge
  output logic      fall      // One-cycle falling edge
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign q    = s2;
  assign rise = ce & s2 & ~s3;
  assign fall = ce & ~s2 & s3;
endmodule : sdp_sync
`default_nettype wire

// *** logic/sdp_mem_port.sv ***
// Memory side: turns word requests into a single-cycle memory access
`timescale 1ns/1ps
`default_nettype none
module sdp_mem_port (
  input  wire logic  sys_clk,   // System clock
  input  wire logic  rst_n,     // Async reset, active low
  input  wire logic  ce,        // Clock enable
  sdp_mem_if.slave   mif,       // Engine side
  output logic       mem_en,    // Memory strobe, one cycle
  output logic       mem_we,    // Write when high
  output logic [15:0] mem_addr, // Word address
  output logic [15:0] mem_wdata,// Write data
  input  wire logic [15:0] mem_rdata // Read data, valid the cycle after strobe
);
  logic pend;
  assign mem_en    = ce & mif.req;
  assign mem_we    = mif.we;
  assign mem_addr  = mif.addr;
  assign mem_wdata = mif.wdata;
  assign mif.rdata = mem_rdata;
  assign mif.ack   = pend;
  // Read data captured by the engine on ack, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (ce) begin
      pend <= mif.req;
    end
  end
endmodule : sdp_mem_port
`default_nettype wire

// *** verif/sdp_spi_master.sv ***
// Behavioural serial master driving the debug port pins
`timescale 1ns/1ps
`default_nettype none
module sdp_spi_master (
  output logic      spi_clk,  // Serial clock, low between frames
  output logic      spi_cs_n, // Chip select, active low
  output logic      spi_mosi, // Serial data to device
  input  wire logic spi_miso  // Point-to-point, never shared
);
  time half = 80ns;
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // ==========================================================
  // Bit and word level
  task automatic bit_io(input logic b, output logic r);
    spi_mosi = b;
    #half spi_clk = 1'b1;
    r = spi_miso;
    #half spi_clk = 1'b0;
  endtask : bit_io
  task automatic word(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) bit_io(tx[i], rx[i]);
  endtask : word
  // ==========================================================
  // Framing
  task automatic start(input logic [7:0] cmd, input logic [15:0] addr);
    logic        r;
    logic [15:0] d;
    #20 spi_cs_n = 1'b0;
    #half;
    for (int i = 7; i >= 0; i--) bit_io(cmd[i], r);
    word(addr, d);
  endtask : start
  task automatic stop();
    #half spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // Released line must not keep its last value
    #(4 * half);
  endtask : stop
  task automatic resync();
    logic r;
    spi_cs_n = 1'b1;
    repeat (2) bit_io(~spi_mosi, r);
    #(4 * half);
  endtask : resync
endmodule : sdp_spi_master
`default_nettype wire

// *** verif/tb_sdp_debug_port.sv ***
// Self-checking bench for the serial debug memory port
`timescale 1ns/1ps
`default_nettype none
module tb_sdp_debug_port;
  logic        sys_clk, rst_n, cpu_halted, spi_clk, spi_cs_n, spi_mosi, spi_miso;
  logic        mem_en, mem_we, rd_hit;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, rd_addr;
  logic [15:0] mem [256];
  logic [15:0] wr_a [$];
  int          failures, n_checks, n_wr, n_rd;

  sdp_debug_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .cpu_halted(cpu_halted),
    .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  sdp_spi_master u_m (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));

  // ==========================================================
  // Memory model: read data presented the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_hit <= mem_en & ~mem_we;
    if (mem_en === 1'b1) begin
      rd_addr <= mem_addr;
      if (mem_we) begin
        mem[mem_addr[7:0]] <= mem_wdata;
        wr_a.push_back(mem_addr);
        n_wr++;
      end else begin
        n_rd++;
      end
    end
  end
  always @(negedge sys_clk) if (rd_hit === 1'b1) mem_rdata <= mem[rd_addr[7:0]];

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // ==========================================================
  // Scenarios
  task automatic t_idle();
    for (int h = 0; h < 2; h++) begin
      @(negedge sys_clk) cpu_halted = h[0];
      repeat (10) @(posedge sys_clk);
      check({15'h0, spi_miso}, {15'h0, h[0]});
    end
  endtask : t_idle
  task automatic t_write();
    logic [15:0] d;
    n_wr = 0;
    n_rd = 0;
    wr_a.delete();
    u_m.start(sdp_pkg::CMD_WRITE, 16'h5a10);
    u_m.word(16'h1234, d);
    u_m.word(16'habcd, d);
    u_m.stop();
    check(16'(n_wr), 16'd2);
    check(16'(n_rd), 16'd0);
    check(wr_a[0], 16'h5a10);
    check(wr_a[1], 16'h5a11);
    check(mem[8'h10], 16'h1234);
    check(mem[8'h11], 16'habcd);
  endtask : t_write
  task automatic t_read();
    logic [15:0] d;
    n_wr = 0;
    u_m.half = 240ns;
    u_m.start(sdp_pkg::CMD_READ, 16'h5a10);
    u_m.word(16'h0000, d);
    check(d, {sdp_pkg::CMD_READ, 8'h5a});
    u_m.word(16'h0000, d);
    check(d, 16'h1234);
    u_m.word(16'h0000, d);
    check(d, 16'habcd);
    u_m.stop();
    u_m.half = 80ns;
    check(16'(n_wr), 16'd0);
  endtask : t_read
  task automatic t_refuse();
    logic [15:0] d;
    logic        r;
    n_wr = 0;
    n_rd = 0;
    u_m.start(8'ha5, 16'h5a10);
    u_m.word(16'h1111, d);
    u_m.stop();
    check(16'(n_wr + n_rd), 16'd0);
    u_m.start(sdp_pkg::CMD_WRITE, 16'h5a20);
    for (int i = 0; i < 8; i++) u_m.bit_io(1'b1, r);
    u_m.stop();
    check(16'(n_wr), 16'd0);
    u_m.resync();
    u_m.start(sdp_pkg::CMD_WRITE, 16'h5a20);
    u_m.word(16'h0f0f, d);
    u_m.stop();
    check(mem[8'h20], 16'h0f0f);
  endtask : t_refuse

  initial begin
    rst_n      = 1'b0;
    cpu_halted = 1'b0;
    mem_rdata  = 16'h0;
    rd_hit     = 1'b0;
    failures   = 0;
    n_checks   = 0;
    foreach (mem[i]) mem[i] = 16'h0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    u_m.resync();
    t_idle();
    t_write();
    t_read();
    t_refuse();
    close_out();
  end

  // Whole run needs well under 150 us
  initial begin
    #1ms;
    failures++;
    close_out();
  end
endmodule : tb_sdp_debug_port
`default_nettype wire
